// File: eelc_top.sv
// Event line controller: edge select, masks, pending, triggers, requests
`timescale 1ns/1ps
`include "eelc_defines.svh"
module eelc_top
  import eelc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic [3:0]  wr_be,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  input  wire eelc_gpio_t  gpio_pins,
  input  wire logic        supply_monitor_in,
  input  wire logic        comp1_in,
  input  wire logic        comp2_in,
  input  wire logic        comp3_in,
  input  wire logic        calendar_in,
  input  wire logic        low_power_timer_in,
  input  wire logic        stop_mode,
  output logic      [31:0] irq_line,
  output logic             irq_lines0_1,
  output logic             irq_lines2_3,
  output logic             irq_lines4_15,
  output logic             irq_supply_monitor,
  output logic             irq_comp,
  output logic             irq_calendar,
  output logic             irq_low_power_timer,
  output logic             event_pulse,
  output logic             wakeup_req
);

  // ============================================================
  // Byte-lane merge, shared by every writable register
  function automatic eelc_vec_t merge_be(
    input eelc_vec_t  old_v,
    input eelc_vec_t  new_v,
    input logic [3:0] be
  );
    eelc_vec_t res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ============================================================
  // Line sources and edge detection
  eelc_line_if lines ();

  eelc_psel_t psel_q;
  eelc_psel_t psel_d;
  eelc_vec_t  periph_raw;

  always_comb begin
    periph_raw = `EELC_RST_ZERO;
    periph_raw[`EELC_LINE_SUPPLY] = supply_monitor_in;
    periph_raw[`EELC_LINE_COMP1]  = comp1_in;
    periph_raw[`EELC_LINE_COMP2]  = comp2_in;
    periph_raw[`EELC_LINE_CAL]    = calendar_in;
    periph_raw[`EELC_LINE_COMP3]  = comp3_in;
    periph_raw[`EELC_LINE_LPT]    = low_power_timer_in;
  end

  // ============================================================
  // Pin synchroniser ahead of the port multiplexer; the mux then
  // switches between settled levels, never between raw pin values
  eelc_gpio_t pin_meta_q, pin_meta_d;
  eelc_gpio_t pin_sync_q, pin_sync_d;
  eelc_vec_t  per_meta_q, per_meta_d;
  eelc_vec_t  per_sync_q, per_sync_d;

  always_comb begin
    pin_meta_d = gpio_pins;
    pin_sync_d = pin_meta_q;
    per_meta_d = periph_raw;
    per_sync_d = per_meta_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta_q <= `EELC_RST_PINS;
      pin_sync_q <= `EELC_RST_PINS;
      per_meta_q <= `EELC_RST_ZERO;
      per_sync_q <= `EELC_RST_ZERO;
    end else begin
      pin_meta_q <= pin_meta_d;
      pin_sync_q <= pin_sync_d;
      per_meta_q <= per_meta_d;
      per_sync_q <= per_sync_d;
    end
  end

  assign lines.gpio_pins  = pin_sync_q;
  assign lines.port_sel   = psel_q;
  assign lines.periph_raw = per_sync_q;

  // Port selection sits ahead of edge detection; changing it can show
  // as one spurious edge, so reprogram with the line masked.
  eelc_port_mux u_mux (
    .lines (lines.mux)
  );

  eelc_sync u_sync (
    .clk   (clk),
    .rst   (rst),
    .lines (lines.sync)
  );

  // ============================================================
  // Registers
  eelc_vec_t rtsr_q, rtsr_d;
  eelc_vec_t ftsr_q, ftsr_d;
  eelc_vec_t swtr_q, swtr_d;
  eelc_vec_t pend_q, pend_d;
  eelc_vec_t imr_q,  imr_d;
  eelc_vec_t emr_q,  emr_d;
  eelc_vec_t rdat_q, rdat_d;

  logic      wr_rtsr, wr_ftsr, wr_swtr;
  logic      wr_pend, wr_imr, wr_emr, wr_psel;
  eelc_vec_t wmask;
  eelc_vec_t pend_clr;
  eelc_vec_t sw_set;
  eelc_vec_t sw_trig;
  eelc_vec_t hw_trig;
  eelc_vec_t cfg_trig;
  eelc_vec_t dir_trig;
  eelc_vec_t psel_flat;

  always_comb begin
    wr_rtsr = wr_en && (addr == `EELC_OFS_RTSR);
    wr_ftsr = wr_en && (addr == `EELC_OFS_FTSR);
    wr_swtr = wr_en && (addr == `EELC_OFS_SWTR);
    wr_pend = wr_en && (addr == `EELC_OFS_PEND);
    wr_imr  = wr_en && (addr == `EELC_OFS_IMR);
    wr_emr  = wr_en && (addr == `EELC_OFS_EMR);
    wr_psel = wr_en && (addr == `EELC_OFS_PSEL);
    // Only the written byte lanes carry ones into set/clear actions
    wmask   = merge_be(`EELC_RST_ZERO, wr_data, wr_be);
  end

  // ============================================================
  // Trigger logic
  always_comb begin
    // Selected edges on configurable lines
    hw_trig  = ((lines.line_rise & rtsr_q) |
                (lines.line_fall & ftsr_q)) & `EELC_CFG_MASK;
    // Software trigger fires on its bit going from 0 to 1
    sw_set   = wr_swtr ? (wmask & `EELC_CFG_MASK)
                       : `EELC_RST_ZERO;
    sw_trig  = sw_set & ~swtr_q;
    cfg_trig = hw_trig | sw_trig;
    // Direct lines: rising edge only, and only in stop state
    dir_trig = stop_mode ? (lines.line_rise & `EELC_DIR_MASK)
                         : `EELC_RST_ZERO;
    pend_clr = wr_pend ? (wmask & `EELC_CFG_MASK)
                       : `EELC_RST_ZERO;
  end

  always_comb begin
    rtsr_d = wr_rtsr ? (merge_be(rtsr_q, wr_data, wr_be) & `EELC_CFG_MASK)
                     : rtsr_q;
    ftsr_d = wr_ftsr ? (merge_be(ftsr_q, wr_data, wr_be) & `EELC_CFG_MASK)
                     : ftsr_q;
    imr_d  = wr_imr  ? (merge_be(imr_q, wr_data, wr_be) &
                        (`EELC_CFG_MASK | `EELC_DIR_MASK)) : imr_q;
    emr_d  = wr_emr  ? (merge_be(emr_q, wr_data, wr_be) &
                        (`EELC_CFG_MASK | `EELC_DIR_MASK)) : emr_q;
    psel_flat = wr_psel ? merge_be(psel_q, wr_data, wr_be) : psel_q;
    psel_d    = psel_flat;
    // A new set beats a clear in the same cycle
    pend_d = (pend_q & ~pend_clr) | (cfg_trig & imr_q);
    // Software bits stay up until their pending flag is cleared
    swtr_d = ((swtr_q & ~pend_clr) | sw_set) & `EELC_CFG_MASK;
  end

  // ============================================================
  // Read data, one cycle after the read strobe
  always_comb begin
    rdat_d = `EELC_RST_ZERO;
    if (rd_en) begin
      case (addr)
        `EELC_OFS_RTSR:  rdat_d = rtsr_q;
        `EELC_OFS_FTSR:  rdat_d = ftsr_q;
        `EELC_OFS_SWTR:  rdat_d = swtr_q;
        `EELC_OFS_PEND:  rdat_d = pend_q;
        `EELC_OFS_IMR:   rdat_d = imr_q;
        `EELC_OFS_EMR:   rdat_d = emr_q;
        `EELC_OFS_PSEL:  rdat_d = psel_q;
        `EELC_OFS_LEVEL: rdat_d = lines.line_level &
                                  (`EELC_CFG_MASK | `EELC_DIR_MASK);
        default:         rdat_d = `EELC_RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rtsr_q <= `EELC_RST_ZERO;
      ftsr_q <= `EELC_RST_ZERO;
      swtr_q <= `EELC_RST_ZERO;
      pend_q <= `EELC_RST_ZERO;
      imr_q  <= `EELC_RST_IMR;
      emr_q  <= `EELC_RST_ZERO;
      psel_q <= `EELC_RST_ZERO;
      rdat_q <= `EELC_RST_ZERO;
    end else begin
      rtsr_q <= rtsr_d;
      ftsr_q <= ftsr_d;
      swtr_q <= swtr_d;
      pend_q <= pend_d;
      imr_q  <= imr_d;
      emr_q  <= emr_d;
      psel_q <= psel_d;
      rdat_q <= rdat_d;
    end
  end

  assign rd_data = rdat_q;

  // ============================================================
  // Request outputs
  eelc_vec_t irq_q, irq_d;
  logic      ev_q, ev_d;
  logic      wake_q, wake_d;
  logic [6:0] vec_q, vec_d;

  always_comb begin
    // Configurable: level while pending and mask both set;
    // direct: one-cycle pulse, the source peripheral holds the flag
    irq_d = (pend_d & imr_d & `EELC_CFG_MASK) |
            (dir_trig & imr_q);
    // Event path ignores the pending flags entirely
    ev_d  = |((cfg_trig | dir_trig) & emr_q);
    // Any request, hardware or software, also asks for wake-up
    wake_d = (|irq_d) | ev_d;
    vec_d[0] = |irq_d[1:0];
    vec_d[1] = |irq_d[3:2];
    vec_d[2] = |irq_d[15:4];
    vec_d[3] = irq_d[`EELC_LINE_SUPPLY];
    vec_d[4] = irq_d[`EELC_LINE_COMP1] | irq_d[`EELC_LINE_COMP2] |
               irq_d[`EELC_LINE_COMP3];
    vec_d[5] = irq_d[`EELC_LINE_CAL];
    vec_d[6] = irq_d[`EELC_LINE_LPT];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q  <= `EELC_RST_ZERO;
      ev_q   <= 1'b0;
      wake_q <= 1'b0;
      vec_q  <= 7'h00;
    end else begin
      irq_q  <= irq_d;
      ev_q   <= ev_d;
      wake_q <= wake_d;
      vec_q  <= vec_d;
    end
  end

  // Twenty configurable plus two direct lines reach the outputs
  assign irq_line            = irq_q;
  assign irq_lines0_1        = vec_q[0];
  assign irq_lines2_3        = vec_q[1];
  assign irq_lines4_15       = vec_q[2];
  assign irq_supply_monitor  = vec_q[3];
  assign irq_comp            = vec_q[4];
  assign irq_calendar        = vec_q[5];
  assign irq_low_power_timer = vec_q[6];
  assign event_pulse         = ev_q;
  assign wakeup_req          = wake_q;

endmodule

// File: eelc_defines.svh
// Register offsets, field masks, reset values of the event line controller
`ifndef EELC_DEFINES_SVH
`define EELC_DEFINES_SVH

// ============================================================
// Register offsets (byte addresses)
`define EELC_OFS_RTSR     8'h00
`define EELC_OFS_FTSR     8'h04
`define EELC_OFS_SWTR     8'h08
`define EELC_OFS_PEND     8'h0C
`define EELC_OFS_IMR      8'h10
`define EELC_OFS_EMR      8'h14
`define EELC_OFS_PSEL     8'h18
`define EELC_OFS_LEVEL    8'h1C

// ============================================================
// Line classes
`define EELC_CFG_MASK     32'h0017FFFF
`define EELC_DIR_MASK     32'h20080000
`define EELC_GPIO_LINES   16
`define EELC_LINE_SUPPLY  16
`define EELC_LINE_COMP1   17
`define EELC_LINE_COMP2   18
`define EELC_LINE_CAL     19
`define EELC_LINE_COMP3   20
`define EELC_LINE_LPT     29

// ============================================================
// Reset values
`define EELC_RST_ZERO     32'h00000000
`define EELC_RST_IMR      32'h20080000
`define EELC_RST_PINS     64'h0000000000000000

`endif

// File: eelc_pkg.sv
// Types shared by the event line controller modules
package eelc_pkg;

  typedef logic [31:0]      eelc_vec_t;
  typedef logic [15:0]      eelc_pin_vec_t;
  typedef logic [1:0]       eelc_port_idx_t;
  // Four GPIO ports of sixteen pins each
  typedef eelc_pin_vec_t [3:0]  eelc_gpio_t;
  typedef eelc_port_idx_t [15:0] eelc_psel_t;

endpackage

// File: eelc_line_if.sv
// Interface carrying line sources, selections and detected edges
`timescale 1ns/1ps
interface eelc_line_if;
  import eelc_pkg::*;

  eelc_gpio_t  gpio_pins;
  eelc_psel_t  port_sel;
  eelc_vec_t   periph_raw;
  eelc_vec_t   line_raw;
  eelc_vec_t   line_rise;
  eelc_vec_t   line_fall;
  eelc_vec_t   line_level;

  modport mux  (input gpio_pins, input port_sel, input periph_raw,
                output line_raw);
  modport sync (input line_raw, output line_rise, output line_fall,
                output line_level);
  modport ctrl (output gpio_pins, output port_sel, output periph_raw,
                input line_rise, input line_fall, input line_level);
endinterface

// File: eelc_port_mux.sv
// GPIO port selection for lines 0 to 15
`timescale 1ns/1ps
`include "eelc_defines.svh"
module eelc_port_mux
  import eelc_pkg::*;
(
  eelc_line_if.mux lines
);

  // ============================================================
  // Line n takes pin n of the selected port
  always_comb begin
    lines.line_raw = lines.periph_raw;
    for (int n = 0; n < `EELC_GPIO_LINES; n++) begin
      lines.line_raw[n] = lines.gpio_pins[lines.port_sel[n]][n];
    end
  end

endmodule

// File: eelc_sync.sv
// Two-stage synchroniser and edge detector for all lines
`timescale 1ns/1ps
`include "eelc_defines.svh"
module eelc_sync
  import eelc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  eelc_line_if.sync lines
);

  eelc_vec_t meta_q, meta_d;
  eelc_vec_t sync_q, sync_d;
  eelc_vec_t prev_q, prev_d;

  // ============================================================
  // Only the second stage and the previous sample feed the edges
  always_comb begin
    meta_d = lines.line_raw;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= `EELC_RST_ZERO;
      sync_q <= `EELC_RST_ZERO;
      prev_q <= `EELC_RST_ZERO;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign lines.line_rise  = sync_q & ~prev_q;
  assign lines.line_fall  = ~sync_q & prev_q;
  assign lines.line_level = sync_q;

endmodule

// File: eelc_top_properties.sv
// Port-level checks of the event line controller
`timescale 1ns/1ps
`include "eelc_defines.svh"
module eelc_top_properties
  import eelc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wr_data,
  input wire logic [3:0]  wr_be,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rd_data,
  input wire logic        stop_mode,
  input wire logic [31:0] irq_line,
  input wire logic        irq_lines0_1,
  input wire logic        irq_lines2_3,
  input wire logic        irq_lines4_15,
  input wire logic        irq_supply_monitor,
  input wire logic        irq_comp,
  input wire logic        irq_calendar,
  input wire logic        irq_low_power_timer,
  input wire logic        event_pulse,
  input wire logic        wakeup_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ============================================================
  // Checks
  sequence s_clear3;
    wr_en && addr == `EELC_OFS_PEND && wr_be[0] && wr_data[3];
  endsequence
  sequence s_run4;
    !stop_mode [*4];
  endsequence
  rd_idle_zero_a: assert property (
    !$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data not zero outside a read answer");
  wake_follows_a: assert property (
    wakeup_req == (|irq_line || event_pulse))
    else $error("wake-up request differs from requests");
  group_or_a: assert property (irq_lines0_1 == |irq_line[1:0]
    && irq_lines2_3 == |irq_line[3:2] && irq_lines4_15 == |irq_line[15:4])
    else $error("combined vector differs from its lines");
  periph_or_a: assert property (
    irq_comp == (irq_line[17] | irq_line[18] | irq_line[20])
    && irq_supply_monitor == irq_line[16]
    && irq_calendar == irq_line[19] && irq_low_power_timer == irq_line[29])
    else $error("peripheral request differs from its line");
  reserved_quiet_a: assert property ((irq_line & ~(`EELC_CFG_MASK
    | `EELC_DIR_MASK)) == 32'h0)
    else $error("request on a reserved line");
  direct_pulse_a: assert property (
    irq_line[19] |=> !irq_line[19])
    else $error("direct request longer than one cycle");
  timer_pulse_a: assert property (
    irq_line[29] |=> !irq_line[29])
    else $error("timer request longer than one cycle");
  run_blocks_a: assert property (
    s_run4 |=> !irq_line[19] && !irq_line[29])
    else $error("direct request while running");
  pend_clear_a: assert property (s_clear3 |=> !irq_line[3])
    else $error("request kept after pending clear");
  irq_hold_a: assert property (
    irq_line[3] && !wr_en |=> irq_line[3])
    else $error("request dropped without a write");
  event_single_a: assert property (event_pulse |=> !event_pulse)
    else $error("event pulse longer than one cycle");
endmodule

bind eelc_top eelc_top_properties u_props (
  .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_be(wr_be),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .stop_mode(stop_mode),
  .irq_line(irq_line), .irq_lines0_1(irq_lines0_1),
  .irq_lines2_3(irq_lines2_3), .irq_lines4_15(irq_lines4_15),
  .irq_supply_monitor(irq_supply_monitor), .irq_comp(irq_comp),
  .irq_calendar(irq_calendar), .irq_low_power_timer(irq_low_power_timer),
  .event_pulse(event_pulse), .wakeup_req(wakeup_req)
);

// File: eelc_cpu_model.sv
// Processor and power manager stand-in: stop state and event tally
`timescale 1ns/1ps
module eelc_cpu_model
  import eelc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sleep,
  input  wire logic wakeup_req,
  input  wire logic event_pulse,
  output logic      stop_mode,
  output int        ev_cnt
);
  always_ff @(posedge clk) begin
    if (rst) begin
      stop_mode <= 1'b0;
      ev_cnt    <= 0;
    end else begin
      // Wake-up wins over a sleep request in the same cycle
      stop_mode <= wakeup_req ? 1'b0 : (sleep | stop_mode);
      ev_cnt    <= ev_cnt + int'(event_pulse);
    end
  end
endmodule

// File: eelc_top_tb.sv
// Self-checking bench for the event line controller
`timescale 1ns/1ps
`include "eelc_defines.svh"
module eelc_top_tb
  import eelc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        sleep = 1'b0;
  logic        sup = 1'b0;
  logic        cal = 1'b0;
  logic        cmp = 1'b0;
  logic        lpt = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic [3:0]  wr_be = 4'h0;
  eelc_gpio_t  gpio = '0;
  logic [31:0] rd_data;
  logic [31:0] irq_line;
  logic        irq_lines4_15;
  logic        irq_lines2_3;
  logic        irq_calendar;
  logic        irq_comp;
  logic        irq_lpt;
  logic        event_pulse;
  logic        wakeup_req;
  logic        stop_mode;
  int          ev_cnt;
  int          cal_cnt = 0;
  int          lpt_cnt = 0;
  int          fails = 0;
  int          n_checks = 0;

  always #25 clk = ~clk;

  eelc_top dut (
    .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_be(wr_be),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .gpio_pins(gpio),
    .supply_monitor_in(sup), .comp1_in(1'b0), .comp2_in(1'b0),
    .comp3_in(cmp), .calendar_in(cal), .low_power_timer_in(lpt),
    .stop_mode(stop_mode), .irq_line(irq_line), .irq_lines0_1(),
    .irq_lines2_3(irq_lines2_3), .irq_lines4_15(irq_lines4_15),
    .irq_supply_monitor(), .irq_comp(irq_comp),
    .irq_calendar(irq_calendar),
    .irq_low_power_timer(irq_lpt), .event_pulse(event_pulse),
    .wakeup_req(wakeup_req)
  );

  eelc_cpu_model cpu (
    .clk(clk), .rst(rst), .sleep(sleep), .wakeup_req(wakeup_req),
    .event_pulse(event_pulse), .stop_mode(stop_mode), .ev_cnt(ev_cnt)
  );

  always @(posedge clk) begin
    if (irq_calendar === 1'b1) begin
      cal_cnt++;
    end
    if (irq_lpt === 1'b1) begin
      lpt_cnt++;
    end
  end

  // ============================================================
  // Tasks
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_be   <= be;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check("rd_data", rd_data, exp);
  endtask

  // Pin inputs pass two two-stage synchronisers, so allow their full latency
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ============================================================
  // Sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    rd(`EELC_OFS_IMR, `EELC_RST_IMR);
    rd(8'h40, 32'h0);
    wr(`EELC_OFS_RTSR, 32'hFFFFFFFF, 4'hF);
    rd(`EELC_OFS_RTSR, `EELC_CFG_MASK);
    wr(`EELC_OFS_IMR, 32'hFFFFFFFF, 4'h2);
    rd(`EELC_OFS_IMR, 32'h2008FF00);
    wr(`EELC_OFS_IMR, 32'h20080028, 4'hF);
    wr(`EELC_OFS_RTSR, 32'h0, 4'hF);
    wr(`EELC_OFS_SWTR, 32'h8, 4'hF);
    check("irq_lines2_3", {31'h0, irq_lines2_3}, 32'h1);
    rd(`EELC_OFS_PEND, 32'h8);
    check("ev_cnt", 32'(ev_cnt), 32'h0);
    wr(`EELC_OFS_PEND, 32'h0, 4'hF);
    rd(`EELC_OFS_PEND, 32'h8);
    wr(`EELC_OFS_PEND, 32'h8, 4'hF);
    check("irq_line", irq_line, 32'h0);
    rd(`EELC_OFS_SWTR, 32'h0);
    wr(`EELC_OFS_PSEL, 32'h800, 4'hF);
    rd(`EELC_OFS_PSEL, 32'h800);
    wr(`EELC_OFS_FTSR, 32'h20, 4'hF);
    gpio[0][5] <= 1'b1;
    cyc(6);
    gpio[0][5] <= 1'b0;
    cyc(6);
    check("irq_line", irq_line, 32'h0);
    gpio[2][5] <= 1'b1;
    cyc(6);
    check("irq_line", irq_line, 32'h0);
    gpio[2][5] <= 1'b0;
    cyc(6);
    check("irq_line", irq_line, 32'h20);
    check("irq_lines4_15", {31'h0, irq_lines4_15}, 32'h1);
    wr(`EELC_OFS_PEND, 32'h20, 4'hF);
    wr(`EELC_OFS_EMR, 32'h00090000, 4'hF);
    wr(`EELC_OFS_RTSR, 32'h10000, 4'hF);
    sup <= 1'b1;
    cyc(6);
    check("ev_cnt", 32'(ev_cnt), 32'h1);
    rd(`EELC_OFS_PEND, 32'h0);
    cal <= 1'b1;
    cyc(6);
    check("cal_cnt", 32'(cal_cnt), 32'h0);
    cal <= 1'b0;
    wr(`EELC_OFS_SWTR, 32'h80000, 4'hF);
    cyc(6);
    check("cal_cnt", 32'(cal_cnt), 32'h0);
    wr(`EELC_OFS_IMR, 32'h20180000, 4'hF);
    wr(`EELC_OFS_RTSR, 32'h00100000, 4'hF);
    cmp <= 1'b1;
    cyc(6);
    check("irq_comp", {31'h0, irq_comp}, 32'h1);
    rd(`EELC_OFS_LEVEL, 32'h00110000);
    wr(`EELC_OFS_PEND, 32'h00100000, 4'h3);
    check("irq_comp", {31'h0, irq_comp}, 32'h1);
    wr(`EELC_OFS_PEND, 32'h00100000, 4'h4);
    check("irq_comp", {31'h0, irq_comp}, 32'h0);
    @(posedge clk);
    sleep <= 1'b1;
    @(posedge clk);
    sleep <= 1'b0;
    cal   <= 1'b1;
    #1;
    check("stop_mode", {31'h0, stop_mode}, 32'h1);
    cyc(6);
    check("cal_cnt", 32'(cal_cnt), 32'h1);
    check("ev_cnt", 32'(ev_cnt), 32'h2);
    check("stop_mode", {31'h0, stop_mode}, 32'h0);
    // Interrupt served: the source peripheral drops its own flag
    cal <= 1'b0;
    lpt <= 1'b1;
    cyc(6);
    check("lpt_cnt", 32'(lpt_cnt), 32'h0);
    lpt <= 1'b0;
    @(posedge clk);
    sleep <= 1'b1;
    @(posedge clk);
    sleep <= 1'b0;
    lpt   <= 1'b1;
    cyc(6);
    check("lpt_cnt", 32'(lpt_cnt), 32'h1);
    check("ev_cnt", 32'(ev_cnt), 32'h2);
    check("stop_mode", {31'h0, stop_mode}, 32'h0);
    finish_test();
  end
endmodule
